// File: dv/pmi_mdio_host.sv
// station management host driving framed reads and writes
`timescale 1ns/1ps
`default_nettype none
module pmi_mdio_host (
	// management pins
	output logic mdc,
	output wire logic mdioPin,
	input wire logic mdioOut,
	input wire logic mdioOe
);
	logic drv = 1'b0;
	logic hostBit = 1'b1;
	// management clock idles low between frames
	initial mdc = 1'b0;
	// line level: device, then host, else pull-up
	assign mdioPin = mdioOe ? mdioOut : (drv ? hostBit : 1'b1);

	// one frame: preamble, header, turnaround, 16 data bits
	task automatic frame(input logic [1:0] op, input logic [4:0] phy,
		input logic [4:0] ra, input logic [15:0] wd,
		output logic [15:0] rv);
		logic [63:0] v;
		int i;
		v = {32'hffffffff, 2'b01, op, phy, ra, 2'b10, wd};
		rv = 16'h0;
		for (i = 63; i >= 0; i--) begin
			drv = (op == 2'h1) || (i > 17);
			hostBit = v[i];
			#62 mdc = 1'b1;
			if (i < 16) rv[i] = mdioPin;
			#63 mdc = 1'b0;
		end
		drv = 1'b0;
	endtask
endmodule // pmi_mdio_host
`default_nettype wire

// File: dv/pmi_phy_mgmt_chk.sv
// port assertions for the management block
`timescale 1ns/1ps
`default_nettype none
module pmi_phy_mgmt_chk (
	// clocking
	input wire logic clk,
	input wire logic rst,
	// activity and resolved mode
	input wire logic txActive,
	input wire logic rxActive,
	input wire logic fullDuplex,
	input wire logic carrierSense,
	input wire logic collision,
	// pin and event outputs
	input wire logic mdioOut,
	input wire logic mdioOe,
	input wire logic anRestart,
	input wire logic phyIrq
);
	// one clock domain for every check
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	carrier_follow_a: assert property (
		!$past(rst) |-> carrierSense == ($past(fullDuplex) ?
		$past(rxActive) : $past(txActive | rxActive)))
		else $error("carrier sense wrong");
	collision_rule_a: assert property (
		!$past(rst) |-> collision ==
		(!$past(fullDuplex) && $past(txActive & rxActive)))
		else $error("collision wrong");
	coll_needs_cs_a: assert property (
		collision |-> carrierSense)
		else $error("collision without carrier");
	reset_quiet_a: assert property (
		$past(rst) |-> !phyIrq && !mdioOe && mdioOut && !anRestart)
		else $error("outputs not idle after reset");
	turn_zero_a: assert property (
		$rose(mdioOe) |-> !mdioOut)
		else $error("turnaround bit not zero");
	drive_hold_a: assert property (
		$rose(mdioOe) |=> mdioOe [*8])
		else $error("read drive too short");
	idle_high_a: assert property (
		!mdioOe |-> mdioOut)
		else $error("released pin not high");
	restart_pulse_a: assert property (
		anRestart |=> !anRestart)
		else $error("restart pulse too long");
endmodule // pmi_phy_mgmt_chk
`default_nettype wire

// File: dv/pmi_phy_mgmt_tb.sv
// self-checking bench for the management and interrupt block
`timescale 1ns/1ps
`default_nettype none
module pmi_phy_mgmt_tb;
	logic clk, rst, mdc, mdioPin, mdioOut, mdioOe;
	logic [1:0] autoMdixStrap, manualMdixStrap;
	logic internalLinkUp, linkStatus, remoteFault, anComplete;
	logic negSpeed100, negFullDuplex, lineEnergyPresent, txActive, rxActive;
	logic [15:0] lpAbility, anExpansion, word;
	logic [7:0] wakeCtrlStatus;
	logic speed100, fullDuplex, carrierSense, collision, anRestart, phyIrq;
	logic crossoverAutoEnable, crossoverFixedState;
	logic crossoverTimeExtend, energyDetectPowerdown;
	int numErrors = 0;
	int nCompared = 0;
	int n;

	// 200 MHz clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// design with shortened energy timings
	pmi_phy_mgmt #(.ENERGY_DELAY_CYC(40), .ENERGY_PULSE_CYC(20)) i_dut (
		.clk(clk), .rst(rst), .ce(1'b1), .mdc(mdc), .mdioIn(mdioPin),
		.mdioOut(mdioOut), .mdioOe(mdioOe), .autoMdixStrap(autoMdixStrap),
		.manualMdixStrap(manualMdixStrap), .internalLinkUp(internalLinkUp),
		.linkStatus(linkStatus), .remoteFault(remoteFault),
		.anComplete(anComplete), .negSpeed100(negSpeed100),
		.negFullDuplex(negFullDuplex), .lineEnergyPresent(lineEnergyPresent),
		.lpAbility(lpAbility), .anExpansion(anExpansion),
		.wakeCtrlStatus(wakeCtrlStatus), .txActive(txActive),
		.rxActive(rxActive), .speed100(speed100), .fullDuplex(fullDuplex),
		.carrierSense(carrierSense), .collision(collision),
		.crossoverAutoEnable(crossoverAutoEnable),
		.crossoverFixedState(crossoverFixedState),
		.crossoverTimeExtend(crossoverTimeExtend),
		.energyDetectPowerdown(energyDetectPowerdown),
		.anRestart(anRestart), .phyIrq(phyIrq));

	// management host on the serial pins
	pmi_mdio_host i_host (.mdc(mdc), .mdioPin(mdioPin), .mdioOut(mdioOut),
		.mdioOe(mdioOe));

	// comparisons
	task automatic chkWord(input logic [15:0] got, input logic [15:0] exp);
		nCompared++;
		if (got !== exp) begin
			numErrors++;
			$display("wrong value at %0t: word %h not %h", $time, got, exp);
		end
	endtask
	task automatic chkLevel(input logic got, input logic exp);
		nCompared++;
		if (got !== exp) begin
			numErrors++;
			$display("wrong value at %0t: level %b not %b", $time, got, exp);
		end
	endtask
	task automatic chkCount(input int got, input int lo, input int hi);
		nCompared++;
		if (got < lo || got > hi) begin
			numErrors++;
			$display("wrong value at %0t: count %0d", $time, got);
		end
	endtask

	// register access and waits
	task automatic settle;
		repeat (6) @(negedge clk);
	endtask
	task automatic rdReg(input logic [4:0] ra, input logic [15:0] exp);
		logic [15:0] v;
		i_host.frame(2'h2, 5'h01, ra, 16'h0, v);
		chkWord(v, exp);
	endtask
	task automatic wrReg(input logic [4:0] ra, input logic [15:0] d);
		logic [15:0] v;
		i_host.frame(2'h1, 5'h01, ra, d, v);
		settle;
	endtask
	task automatic irqIs(input logic e);
		settle;
		chkLevel(phyIrq, e);
	endtask

	// verdict and end of run
	task automatic closeOut;
		$display("compared %0d errors %0d", nCompared, numErrors);
		if (numErrors == 0 && nCompared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// watchdog against a hung run
	initial begin
		#400000;
		numErrors++;
		$display("wrong value at %0t: run timed out", $time);
		closeOut;
	end

	// test sequence
	initial begin
		rst = 1'b1;
		{autoMdixStrap, manualMdixStrap} = 4'h2;
		{internalLinkUp, remoteFault, anComplete, negSpeed100} = 4'h0;
		// line energy reads high from power-up, as signal acquisition starts
		{negFullDuplex, lineEnergyPresent, txActive, rxActive} = 4'h4;
		linkStatus = 1'b1;
		lpAbility = 16'h0;
		anExpansion = 16'h0;
		wakeCtrlStatus = 8'h0;
		repeat (12) @(negedge clk);
		rst = 1'b0;
		repeat (4) @(negedge clk);
		chkLevel(crossoverAutoEnable, 1'b0);
		chkLevel(crossoverFixedState, 1'b1);
		chkLevel(phyIrq, 1'b0);
		rdReg(5'h1d, 16'h0080);
		rdReg(5'h1d, 16'h0000);
		rdReg(5'h00, 16'h3100);
		rdReg(5'h03, 16'hffff);
		i_host.frame(2'h2, 5'h02, 5'h00, 16'h0, word);
		chkWord(word, 16'hffff);
		// mode resolution, carrier and crossover
		negFullDuplex = 1'b1;
		anComplete = 1'b1;
		settle;
		chkLevel(speed100, 1'b0);
		chkLevel(fullDuplex, 1'b1);
		chkLevel(phyIrq, 1'b0);
		wrReg(5'h00, 16'h2000);
		chkLevel(speed100, 1'b1);
		chkLevel(fullDuplex, 1'b0);
		{txActive, rxActive} = 2'h3;
		settle;
		chkLevel(collision, 1'b1);
		wrReg(5'h00, 16'h0100);
		rxActive = 1'b0;
		settle;
		chkLevel(carrierSense, 1'b0);
		wrReg(5'h10, 16'h0002);
		chkLevel(crossoverTimeExtend, 1'b1);
		wrReg(5'h10, 16'h0001);
		wrReg(5'h11, 16'h2000);
		chkLevel(energyDetectPowerdown, 1'b1);
		chkLevel(crossoverTimeExtend, 1'b1);
		wrReg(5'h1b, 16'hc000);
		chkLevel(crossoverAutoEnable, 1'b1);
		chkLevel(crossoverFixedState, 1'b0);
		// mask, aggregation and primary clears
		wrReg(5'h1e, 16'hffff);
		rdReg(5'h1e, 16'h03fe);
		wrReg(5'h1e, 16'h0040);
		irqIs(1'b1);
		rdReg(5'h1d, 16'h0040);
		irqIs(1'b0);
		anComplete = 1'b0;
		settle;
		anComplete = 1'b1;
		irqIs(1'b1);
		anComplete = 1'b0;
		irqIs(1'b0);
		wrReg(5'h1e, 16'h0308);
		internalLinkUp = 1'b1;
		irqIs(1'b1);
		internalLinkUp = 1'b0;
		irqIs(1'b0);
		lpAbility = 16'h4000;
		irqIs(1'b1);
		lpAbility = 16'h0;
		irqIs(1'b0);
		wakeCtrlStatus = 8'h21;
		irqIs(1'b0);
		wakeCtrlStatus = 8'h22;
		irqIs(1'b1);
		wakeCtrlStatus = 8'h0;
		irqIs(1'b0);
		// link down and remote fault
		wrReg(5'h1e, 16'h0030);
		linkStatus = 1'b0;
		irqIs(1'b1);
		linkStatus = 1'b1;
		irqIs(1'b1);
		rdReg(5'h01, 16'h780d);
		irqIs(1'b0);
		remoteFault = 1'b1;
		irqIs(1'b1);
		rdReg(5'h01, 16'h781d);
		irqIs(1'b0);
		// fault and page flags
		wrReg(5'h1e, 16'h0006);
		anExpansion = 16'h0002;
		irqIs(1'b1);
		rdReg(5'h06, 16'h0002);
		irqIs(1'b0);
		anExpansion = 16'h0010;
		irqIs(1'b1);
		wrReg(5'h00, 16'h1200);
		chkLevel(phyIrq, 1'b0);
		anExpansion = 16'h0012;
		irqIs(1'b1);
		linkStatus = 1'b0;
		irqIs(1'b0);
		linkStatus = 1'b1;
		rdReg(5'h01, 16'h781d);
		// alternative mode
		wrReg(5'h11, 16'h0040);
		wrReg(5'h1e, 16'h0020);
		remoteFault = 1'b0;
		settle;
		remoteFault = 1'b1;
		irqIs(1'b1);
		rdReg(5'h1d, 16'h0020);
		wrReg(5'h1d, 16'h0020);
		chkLevel(phyIrq, 1'b1);
		remoteFault = 1'b0;
		wrReg(5'h1d, 16'h0020);
		chkLevel(phyIrq, 1'b0);
		wrReg(5'h11, 16'h0000);
		// delayed energy pulse after removal
		lineEnergyPresent = 1'b0;
		wrReg(5'h1e, 16'h0080);
		lineEnergyPresent = 1'b1;
		irqIs(1'b1);
		rdReg(5'h1d, 16'h0080);
		irqIs(1'b0);
		lineEnergyPresent = 1'b0;
		n = 0;
		while (phyIrq !== 1'b1 && n < 200) begin
			@(negedge clk);
			n++;
		end
		chkCount(n, 39, 46);
		n = 0;
		while (phyIrq === 1'b1 && n < 200) begin
			@(negedge clk);
			n++;
		end
		chkCount(n, 20, 20);
		wrReg(5'h1e, 16'h0000);
		closeOut;
	end
endmodule // pmi_phy_mgmt_tb

// checker beside the design
bind pmi_phy_mgmt pmi_phy_mgmt_chk i_chk (.clk(clk), .rst(rst),
	.txActive(txActive), .rxActive(rxActive), .fullDuplex(fullDuplex),
	.carrierSense(carrierSense), .collision(collision),
	.mdioOut(mdioOut), .mdioOe(mdioOe), .anRestart(anRestart),
	.phyIrq(phyIrq));
`default_nettype wire

// File: rtl/pmi_defines.vh
// constants of the transceiver management and interrupt block
`ifndef PMI_DEFINES_VH
`define PMI_DEFINES_VH

// management register addresses
`define PMI_REG_BCTL 5'h00
`define PMI_REG_BSTS 5'h01
`define PMI_REG_LPAB 5'h05
`define PMI_REG_ANEX 5'h06
`define PMI_REG_EDCF 5'h10
`define PMI_REG_MCSR 5'h11
`define PMI_REG_SCSI 5'h1b
`define PMI_REG_FLAG 5'h1d
`define PMI_REG_MASK 5'h1e
`define PMI_UNSUPPORTED 16'hffff

// basic control fields
`define PMI_BCTL_RESET 16'h3100
`define PMI_BCTL_WMASK 16'h3100
`define PMI_BCTL_SPEED 13
`define PMI_BCTL_AN 12
`define PMI_BCTL_RESTART 9
`define PMI_BCTL_DUPLEX 8

// basic status fields
`define PMI_BSTS_FIXED 16'h7809
`define PMI_BSTS_ANDONE 5
`define PMI_BSTS_RFAULT 4
`define PMI_BSTS_LINK 2
`define PMI_LPAB_ACK 14
`define PMI_ANEX_PDF 4
`define PMI_ANEX_PAGE 1

// vendor registers
`define PMI_EDCF_WMASK 16'h0003
`define PMI_EDCF_MANEXT 1
`define PMI_EDCF_EDEXT 0
`define PMI_MCSR_WMASK 16'h2040
`define PMI_MCSR_ENERGY_DETECT_POWERDOWN 13
`define PMI_MCSR_ALT 6
`define PMI_MCSR_ENERGY 1
`define PMI_SCSI_WMASK 16'he000
`define PMI_SCSI_OVR 15
`define PMI_SCSI_AUTO 14
`define PMI_SCSI_FIXED 13

// flag register: bits 9 down to 1
`define PMI_FLAG_RESET 16'h0080
`define PMI_FLAG_WMASK 16'h03fe
`define PMI_FLAG_LINKUP 9
`define PMI_FLAG_ENERGY 7
`define PMI_FLAG_LINKDN 4
`define PMI_FLAG_RFAULT 5
`define PMI_FLAG_PDF 2

// serial frame
`define PMI_PRE_ONES 6'h20
`define PMI_OP_READ 2'h2
`define PMI_OP_WRITE 2'h1
`define PMI_DATA_LAST 5'h0f
`define PMI_DATA_END 5'h10
`define PMI_HDR_LAST 4'hb

// energy re-assert timing
`define PMI_CLK_KHZ 200000
`define PMI_ENERGY_DELAY_MS 1000
`define PMI_ENERGY_PULSE_MS 256

`endif

// File: rtl/pmi_energy_timer.v
// delayed energy re-assert pulse after cable removal
`timescale 1ns/1ps
`default_nettype none
module pmi_energy_timer #(
	parameter DELAY_CYC = 200000000,
	parameter PULSE_CYC = 51200000
) (
	// clocking
	input wire clk,
	input wire rst,
	input wire ce,
	// events
	input wire arm,
	input wire maskOn,
	input wire energyFall,
	output reg pulse
);
	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_ARMED = 2'h1;
	localparam [1:0] ST_WAIT = 2'h2;
	localparam [1:0] ST_PULSE = 2'h3;
	reg [1:0] state;
	reg [31:0] cnt;

	// armed by a deassert while energy stays high, fires after removal
	always @(posedge clk) begin
		if (rst) begin
			state <= ST_IDLE;
			cnt <= 32'h0;
			pulse <= 1'b0;
		end else if (ce) begin
			case (state)
			ST_IDLE: begin
				pulse <= 1'b0;
				if (arm)
					state <= ST_ARMED;
			end
			ST_ARMED: begin
				if (!maskOn)
					state <= ST_IDLE;
				else if (energyFall) begin
					state <= ST_WAIT;
					cnt <= 32'h0;
				end
			end
			ST_WAIT: begin
				if (cnt >= DELAY_CYC - 1) begin
					state <= ST_PULSE;
					cnt <= 32'h0;
					pulse <= maskOn;
				end else
					cnt <= cnt + 32'h1;
			end
			ST_PULSE: begin
				if (cnt >= PULSE_CYC - 1) begin
					state <= ST_IDLE;
					pulse <= 1'b0;
				end else
					cnt <= cnt + 32'h1;
			end
			default: state <= ST_IDLE;
			endcase
		end
	end
endmodule // pmi_energy_timer
`default_nettype wire

// File: rtl/pmi_in_sync.v
// three-stage synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module pmi_in_sync #(
	parameter WIDTH = 2,
	parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
	// clocking
	input wire clk,
	input wire rst,
	input wire ce,
	// data
	input wire [WIDTH-1:0] din,
	output reg [WIDTH-1:0] dout
);
	reg [WIDTH-1:0] s1;
	reg [WIDTH-1:0] s2;
	reg [WIDTH-1:0] s3;

	// output moves only where stages two and three agree
	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
			always @(posedge clk) begin
				if (rst) begin
					s1[i] <= INIT[i];
					s2[i] <= INIT[i];
					s3[i] <= INIT[i];
					dout[i] <= INIT[i];
				end else if (ce) begin
					s1[i] <= din[i];
					s2[i] <= s1[i];
					s3[i] <= s2[i];
					if (s2[i] == s3[i])
						dout[i] <= s3[i];
				end
			end
		end
	endgenerate
endmodule // pmi_in_sync
`default_nettype wire

// File: rtl/pmi_phy_mgmt.v
// transceiver management port, mode control and interrupt flags
`timescale 1ns/1ps
`default_nettype none
`include "pmi_defines.vh"

// How it works
// - autoneg off: speed and duplex follow the forced control bits
// - autoneg on: forced bits ignored, negotiated result used
// - half duplex: carrier on tx or rx, rx during tx is collision
// - full duplex: carrier follows rx only, no collision
// - crossover enable and fixed choice default from the straps
// - override bit set: crossover taken from software enable and state bits
// - forced modes: manual extension bit lengthens crossover time
// - energy-detect powerdown on: its extension bit lengthens crossover
// - unsupported register reads return all ones
// - unmasked flags combine into one interrupt output
// - output asserts only for masked-in events in either mode
// - primary mode after every reset, alternative only when selected
// - primary: flag set on assert event, cleared on deassert event, link-down cleared by read only
// - flags 9..1 with masks; set on rise, clear on fall or read, except link-down
// - link-down sets on link fall, clears on read of 1 or 29
// - fault and page flags also clear on reg 6 read, restart, link loss
// - link-up source is internal status not readable anywhere
// - wake source is OR of status 7:4 AND enable 3:0
// - energy mask on: 256 ms re-assert about 1 s after removal
// - energy flag reads one after reset if line energy stays present
// - alternative mode: write one clears flag only if deassert holds
module pmi_phy_mgmt #(
	parameter [4:0] PHY_ADDR = 5'h01,
	parameter ENERGY_DELAY_CYC = `PMI_ENERGY_DELAY_MS * `PMI_CLK_KHZ,
	parameter ENERGY_PULSE_CYC = `PMI_ENERGY_PULSE_MS * `PMI_CLK_KHZ
) (
	// clocking
	input wire clk,
	input wire rst,
	input wire ce,
	// management serial pins
	input wire mdc,
	input wire mdioIn,
	output reg mdioOut,
	output reg mdioOe,
	// straps
	input wire [1:0] autoMdixStrap,
	input wire [1:0] manualMdixStrap,
	// line status from the transceiver core
	input wire internalLinkUp,
	input wire linkStatus,
	input wire remoteFault,
	input wire anComplete,
	input wire negSpeed100,
	input wire negFullDuplex,
	input wire lineEnergyPresent,
	input wire [15:0] lpAbility,
	input wire [15:0] anExpansion,
	input wire [7:0] wakeCtrlStatus,
	input wire txActive,
	input wire rxActive,
	// resolved mode
	output reg speed100,
	output reg fullDuplex,
	output reg carrierSense,
	output reg collision,
	output reg crossoverAutoEnable,
	output reg crossoverFixedState,
	output reg crossoverTimeExtend,
	output reg energyDetectPowerdown,
	output reg anRestart,
	// interrupt to the system controller
	output reg phyIrq
);
	localparam [2:0] ST_PRE = 3'h0;
	localparam [2:0] ST_START = 3'h1;
	localparam [2:0] ST_HDR = 3'h2;
	localparam [2:0] ST_TA = 3'h3;
	localparam [2:0] ST_RDAT = 3'h4;
	localparam [2:0] ST_WDAT = 3'h5;

	wire mdcS;
	wire mdioS;
	reg mdcPrev;
	reg [2:0] state;
	reg [5:0] ones;
	reg [4:0] cnt;
	reg [10:0] hdr;
	reg isWrite;
	reg [4:0] regAddr;
	reg [15:0] shiftReg;
	reg rdPulse;
	reg wrPulse;
	reg [15:0] wrData;
	reg [15:0] bctl;
	reg [15:0] edcf;
	reg [15:0] mcsr;
	reg [15:0] scsi;
	reg [15:0] flags;
	reg [15:0] mask;
	reg strapAuto;
	reg strapFixed;
	reg [9:1] srcPrev;
	reg [15:0] readData;
	wire mdcRise;
	wire [11:0] hdrFull;
	wire [9:1] src;
	wire [9:1] setEv;
	wire [9:1] deassertOk;
	wire [9:1] clrEv;
	wire [15:0] nextFlags;
	wire energyPulse;
	wire altMode;
	wire rd1;
	wire rd6;
	wire rd29;
	wire wr29;
	wire linkFall;

	// address match, used for reads and for writes
	function hit;
		input [4:0] a;
		input [4:0] b;
		begin
			hit = (a == b);
		end
	endfunction

	// pin inputs cross into the clock domain
	pmi_in_sync #(
		.WIDTH(2),
		.INIT(2'b10)
	) u_sync (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.din({mdioIn, mdc}),
		.dout({mdioS, mdcS})
	);

	assign mdcRise = mdcS & ~mdcPrev;
	assign hdrFull = {hdr, mdioS};

	// serial frame: preamble, start, header, turnaround, data
	always @(posedge clk) begin
		if (rst) begin
			mdcPrev <= 1'b0;
			state <= ST_PRE;
			ones <= 6'h0;
			cnt <= 5'h0;
			hdr <= 11'h0;
			isWrite <= 1'b0;
			regAddr <= 5'h0;
			shiftReg <= 16'h0;
			rdPulse <= 1'b0;
			wrPulse <= 1'b0;
			wrData <= 16'h0;
			mdioOut <= 1'b1;
			mdioOe <= 1'b0;
		end else if (ce) begin
			mdcPrev <= mdcS;
			rdPulse <= 1'b0;
			wrPulse <= 1'b0;
			if (mdcRise) begin
				case (state)
				ST_PRE: begin
					if (mdioS) begin
						if (ones != `PMI_PRE_ONES)
							ones <= ones + 6'h1;
					end else if (ones == `PMI_PRE_ONES)
						state <= ST_START;
					else
						ones <= 6'h0;
				end
				ST_START: begin
					ones <= 6'h0;
					cnt <= 5'h0;
					state <= mdioS ? ST_HDR : ST_PRE;
				end
				ST_HDR: begin
					hdr <= hdrFull[10:0];
					cnt <= cnt + 5'h1;
					if (cnt[3:0] == `PMI_HDR_LAST) begin
						cnt <= 5'h0;
						regAddr <= hdrFull[4:0];
						isWrite <= (hdrFull[11:10] == `PMI_OP_WRITE);
						if (!hit(hdrFull[9:5], PHY_ADDR))
							state <= ST_PRE;
						else if (hdrFull[11:10] == `PMI_OP_READ) begin
							state <= ST_TA;
							shiftReg <= readData;
							rdPulse <= 1'b1;
						end else if (hdrFull[11:10] == `PMI_OP_WRITE)
							state <= ST_TA;
						else
							state <= ST_PRE;
					end
				end
				ST_TA: begin
					cnt <= 5'h1;
					if (cnt != 5'h0) begin
						cnt <= 5'h0;
						state <= ST_WDAT;
						if (!isWrite) begin
							mdioOut <= shiftReg[15];
							shiftReg <= {shiftReg[14:0], 1'b0};
							cnt <= 5'h1;
							state <= ST_RDAT;
						end
					end else if (!isWrite) begin
						mdioOe <= 1'b1;
						mdioOut <= 1'b0;
					end
				end
				ST_RDAT: begin
					if (cnt == `PMI_DATA_END) begin
						mdioOe <= 1'b0;
						mdioOut <= 1'b1;
						state <= ST_PRE;
					end else begin
						mdioOut <= shiftReg[15];
						shiftReg <= {shiftReg[14:0], 1'b0};
						cnt <= cnt + 5'h1;
					end
				end
				ST_WDAT: begin
					shiftReg <= {shiftReg[14:0], mdioS};
					cnt <= cnt + 5'h1;
					if (cnt == `PMI_DATA_LAST) begin
						wrData <= {shiftReg[14:0], mdioS};
						wrPulse <= 1'b1;
						state <= ST_PRE;
					end
				end
				default: state <= ST_PRE;
				endcase
			end
		end
	end

	// register read view, all ones where nothing is mapped
	always @* begin
		readData = `PMI_UNSUPPORTED;
		case (hdrFull[4:0])
		`PMI_REG_BCTL: readData = bctl;
		`PMI_REG_BSTS: begin
			readData = `PMI_BSTS_FIXED;
			readData[`PMI_BSTS_ANDONE] = anComplete;
			readData[`PMI_BSTS_RFAULT] = remoteFault;
			readData[`PMI_BSTS_LINK] = linkStatus;
		end
		`PMI_REG_LPAB: readData = lpAbility;
		`PMI_REG_ANEX: readData = anExpansion;
		`PMI_REG_EDCF: readData = edcf;
		`PMI_REG_MCSR: begin
			readData = mcsr;
			readData[`PMI_MCSR_ENERGY] = lineEnergyPresent;
		end
		`PMI_REG_SCSI: readData = scsi;
		`PMI_REG_FLAG: readData = flags;
		`PMI_REG_MASK: readData = mask;
		default: readData = `PMI_UNSUPPORTED;
		endcase
	end

	// writable registers; primary mode after every reset
	always @(posedge clk) begin
		if (rst) begin
			bctl <= `PMI_BCTL_RESET;
			edcf <= 16'h0;
			mcsr <= 16'h0;
			scsi <= 16'h0;
			mask <= 16'h0;
			anRestart <= 1'b0;
			strapAuto <= |autoMdixStrap;
			strapFixed <= |manualMdixStrap;
		end else if (ce) begin
			anRestart <= 1'b0;
			if (wrPulse) begin
				if (hit(regAddr, `PMI_REG_BCTL)) begin
					bctl <= wrData & `PMI_BCTL_WMASK;
					anRestart <= wrData[`PMI_BCTL_RESTART];
				end
				if (hit(regAddr, `PMI_REG_EDCF))
					edcf <= wrData & `PMI_EDCF_WMASK;
				if (hit(regAddr, `PMI_REG_MCSR))
					mcsr <= wrData & `PMI_MCSR_WMASK;
				if (hit(regAddr, `PMI_REG_SCSI))
					scsi <= wrData & `PMI_SCSI_WMASK;
				if (hit(regAddr, `PMI_REG_MASK))
					mask <= wrData & `PMI_FLAG_WMASK;
			end
		end
	end

	// interrupt sources in flag bit order
	assign src[9] = internalLinkUp;
	assign src[8] = |(wakeCtrlStatus[7:4] & wakeCtrlStatus[3:0]);
	assign src[7] = lineEnergyPresent;
	assign src[6] = anComplete;
	assign src[5] = remoteFault;
	assign src[4] = linkStatus;
	assign src[3] = lpAbility[`PMI_LPAB_ACK];
	assign src[2] = anExpansion[`PMI_ANEX_PDF];
	assign src[1] = anExpansion[`PMI_ANEX_PAGE];

	assign altMode = mcsr[`PMI_MCSR_ALT];
	assign rd1 = rdPulse & hit(regAddr, `PMI_REG_BSTS);
	assign rd6 = rdPulse & hit(regAddr, `PMI_REG_ANEX);
	assign rd29 = rdPulse & hit(regAddr, `PMI_REG_FLAG);
	assign wr29 = wrPulse & hit(regAddr, `PMI_REG_FLAG);
	assign linkFall = srcPrev[4] & ~linkStatus;

	// per-flag set and clear; set wins over any clear
	genvar i;
	generate
		for (i = 1; i <= 9; i = i + 1) begin : g_flag
			if (i == `PMI_FLAG_LINKDN) begin : g_dn
				assign setEv[i] = srcPrev[i] & ~src[i];
				assign deassertOk[i] = src[i];
				assign clrEv[i] = altMode ? (wr29 & wrData[i] & deassertOk[i])
					: (rd1 | rd29);
			end else begin : g_up
				wire extra;
				if (i == `PMI_FLAG_RFAULT) begin : g_rf
					assign extra = rd1;
				end else if (i <= `PMI_FLAG_PDF) begin : g_an
					assign extra = rd6 | anRestart | linkFall;
				end else begin : g_none
					assign extra = 1'b0;
				end
				assign setEv[i] = src[i] & ~srcPrev[i];
				assign deassertOk[i] = ~src[i];
				assign clrEv[i] = altMode ? (wr29 & wrData[i] & deassertOk[i])
					: ((srcPrev[i] & ~src[i]) | rd29 | extra);
			end
			assign nextFlags[i] = setEv[i] | (flags[i] & ~clrEv[i]);
		end
	endgenerate
	assign nextFlags[15:10] = 6'h0;
	assign nextFlags[0] = 1'b0;

	// flag register and source history; energy flag starts set
	always @(posedge clk) begin
		if (rst) begin
			flags <= `PMI_FLAG_RESET;
			srcPrev <= 9'h0;
			srcPrev[`PMI_FLAG_ENERGY] <= 1'b1;
		end else if (ce) begin
			flags <= nextFlags;
			srcPrev <= src;
		end
	end

	// delayed energy re-assert after cable removal
	pmi_energy_timer #(
		.DELAY_CYC(ENERGY_DELAY_CYC),
		.PULSE_CYC(ENERGY_PULSE_CYC)
	) u_energy (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.arm(mask[`PMI_FLAG_ENERGY] & flags[`PMI_FLAG_ENERGY]
			& ~nextFlags[`PMI_FLAG_ENERGY] & lineEnergyPresent),
		.maskOn(mask[`PMI_FLAG_ENERGY]),
		.energyFall(srcPrev[`PMI_FLAG_ENERGY] & ~lineEnergyPresent),
		.pulse(energyPulse)
	);

	// resolved mode, carrier, crossover and interrupt outputs
	always @(posedge clk) begin
		if (rst) begin
			speed100 <= 1'b0;
			fullDuplex <= 1'b0;
			carrierSense <= 1'b0;
			collision <= 1'b0;
			crossoverAutoEnable <= 1'b0;
			crossoverFixedState <= 1'b0;
			crossoverTimeExtend <= 1'b0;
			energyDetectPowerdown <= 1'b0;
			phyIrq <= 1'b0;
		end else if (ce) begin
			if (bctl[`PMI_BCTL_AN]) begin
				speed100 <= negSpeed100;
				fullDuplex <= negFullDuplex;
			end else begin
				speed100 <= bctl[`PMI_BCTL_SPEED];
				fullDuplex <= bctl[`PMI_BCTL_DUPLEX];
			end
			if (fullDuplex) begin
				carrierSense <= rxActive;
				collision <= 1'b0;
			end else begin
				carrierSense <= rxActive | txActive;
				collision <= rxActive & txActive;
			end
			if (scsi[`PMI_SCSI_OVR]) begin
				crossoverAutoEnable <= scsi[`PMI_SCSI_AUTO];
				crossoverFixedState <= scsi[`PMI_SCSI_FIXED];
			end else begin
				crossoverAutoEnable <= strapAuto;
				crossoverFixedState <= strapFixed;
			end
			crossoverTimeExtend <=
				(~bctl[`PMI_BCTL_AN] & edcf[`PMI_EDCF_MANEXT])
				| (mcsr[`PMI_MCSR_ENERGY_DETECT_POWERDOWN] & edcf[`PMI_EDCF_EDEXT]);
			energyDetectPowerdown <= mcsr[`PMI_MCSR_ENERGY_DETECT_POWERDOWN];
			phyIrq <= |(flags & mask) | energyPulse;
		end
	end
endmodule // pmi_phy_mgmt
`default_nettype wire
